// ### cswl_pkg.sv
// Shared constants and types for the CAN selective wake logic
package cswl_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ID = 8'h04;
  localparam logic [7:0] ADDR_IDMASK = 8'h08;
  localparam logic [7:0] ADDR_DLC = 8'h0c;
  localparam logic [7:0] ADDR_DMASK_LO = 8'h10;
  localparam logic [7:0] ADDR_DMASK_HI = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam logic [7:0] ADDR_WAKE = 8'h1c;

  // Control and ID register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FLEX = 3;
  localparam int CTRL_CDIS = 4;
  localparam int CTRL_CFGV = 5;
  localparam int CTRL_TOMASK = 6;
  localparam int ID_IDE = 29;

  // Status and wake register fields
  localparam int ST_WPAT = 0;
  localparam int ST_WFRM = 1;
  localparam int ST_SYSTEM_ERROR_FLAG = 2;
  localparam int ST_BTO = 3;
  localparam int ST_BSIL = 4;
  localparam int ST_SYNC = 5;
  localparam int ST_ARMED = 6;
  localparam int ST_ERROR_COUNT_FIELD_LSB = 8;
  localparam int WK_BUSWK = 0;

  // Mode codes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_WK = 3'h1;
  localparam logic [2:0] MODE_RXONLY = 3'h2;
  localparam logic [2:0] MODE_NORMAL = 3'h3;
  localparam logic [2:0] MODE_OFF_ALT = 3'h4;
  localparam logic [2:0] MODE_SWK = 3'h5;

  // Power modes of the surrounding chip
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_STOP = 2'h1;
  localparam logic [1:0] PWR_SLEEP = 2'h2;
  localparam logic [1:0] PWR_RESTART = 2'h3;

  // Error counter and decoder resync
  localparam logic [5:0] ERROR_COUNT_FIELD_MAX = 6'h1f;
  localparam logic [5:0] ERROR_COUNT_FIELD_OVF = 6'h20;
  localparam logic [3:0] RESYNC_BITS = 4'h6;
  localparam int IGNORE_MAX = 4;

  // Timing, clock 10 MHz
  localparam int CLK_MHZ = 10;
  localparam int WAKE_MIN_NS = 500;
  localparam int WAKE_CYC_DEF = (WAKE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int SILENCE_US = 1000;
  localparam int SILENCE_CYC_DEF = SILENCE_US * CLK_MHZ;

  typedef enum logic [2:0] {
    CSWL_OFF, CSWL_WK, CSWL_ACTIVE, CSWL_WUF_DET, CSWL_WUP_DET1, CSWL_WUP_DET2, CSWL_WOKEN
  } cswl_state_t;

endpackage

// ### cswl_core.sv
// Selective wake logic: pattern and frame wake, error counter, status flags, APB registers
// How it works
// - Up to four frames after bias on may be ignored before filtering.
// - Frame wake only when selective wake is enabled and frame fully qualifies.
// - Identifier matches configured one in masked bits, standard or extended.
// - Length equal; nonzero length needs a data bit hitting the data mask.
// - Protocol errors disqualify; acknowledge and end-of-frame errors are tolerated.
// - Stuff, CRC, form error counts up; good frame to CRC end counts down.
// - Increment at 31 disables selective wake, wakes, sets system error, shows 32.
// - After each count increment or decrement decoder waits 6 to 10 recessive bits.
// - Counter runs in normal, receive-only, frame detection; frozen when woken.
// - Counter cleared on detection entry, silence, rearm, off modes, disable bits.
// - Pattern wake flag set on detected pattern; cleared at rearm.
// - Frame wake sets frame flag and bus wake bit, restart or interrupt.
// - System error set on config error or overflow in selective modes only.
// - Selecting selective wake runs config check; pass enables and clears error.
// - Config writes in normal mode clear valid bit, raising config error.
// - Restart entry clears valid bit; error unless woken by frame from sleep.
// - System error clear refused while top mode bit set and valid bit clear.
// - Silence expiry sets timeout flag, interrupt if enabled, never wakes sleep.
// - Silence expiry sets silence flag; a later wake pattern clears it.
// - Sync flag set by good frame, cleared by protocol error.
// - Armed flag set on correct enable or after error; cleared on wake.
// - Mode 101 is pure selective wake; programmed code stays readable.
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module cswl_core import cswl_pkg::*; #(
  parameter int SILENCE_CYC = SILENCE_CYC_DEF,
  parameter int WAKE_CYC = WAKE_CYC_DEF,
  parameter int IGN_FRAMES = 2
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_bus_rx,
  input wire logic [1:0] i_pwr_mode,
  input wire logic i_bit_valid,
  input wire logic i_bit_rec,
  input wire logic i_frame_ok,
  input wire logic i_frame_ide,
  input wire logic [28:0] i_frame_id,
  input wire logic [3:0] i_frame_dlc,
  input wire logic [63:0] i_frame_data,
  input wire logic i_err_stuff,
  input wire logic i_err_crc,
  input wire logic i_err_form,
  output logic o_sof_enable,
  output logic o_xcvr_woken,
  output logic o_swk_armed,
  output logic o_irq,
  output logic o_restart_req
);

  typedef struct packed {
    cswl_state_t st;
    logic [2:0] mode;
    logic flex;
    logic cdis;
    logic config_valid_bit;
    logic to_mask;
    logic ide;
    logic [28:0] id;
    logic [28:0] idm;
    logic [3:0] dlc;
    logic [63:0] dmask;
    logic wpat;
    logic wfrm;
    logic system_error_flag;
    logic bto;
    logic bsil;
    logic sync;
    logic armed;
    logic buswk;
    logic swk_en;
    logic [5:0] error_count_field;
    logic rx1;
    logic rx2;
    logic [1:0] pat_ph;
    logic [15:0] dom_cnt;
    logic [23:0] sil_cnt;
    logic [3:0] rec_cnt;
    logic gate;
    logic [2:0] ign;
    logic [1:0] pwr_prev;
    logic fw_sleep;
    logic irq;
    logic restart;
    logic woken;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cswl_regs_t;

  localparam logic [23:0] SIL_LAST = 24'(SILENCE_CYC - 1);
  localparam logic [15:0] WAKE_LAST = 16'(WAKE_CYC - 1);
  localparam logic [2:0] IGN_LIM = 3'(IGN_FRAMES);

  cswl_regs_t q, d;
  logic setup, wr, cfg_hit, rx_dom, prot_err, frame_good, counting, error_count_field_clr;
  logic incr, decr, ovf, id_hit, dlc_hit, data_hit, wake_frame, pat_hit, sil_hit, low_pwr_ok;
  logic mode_wr, restart_entry;
  logic [2:0] new_mode;

  function automatic logic swk_sel(input logic [2:0] m);
    return m[2] && (m != MODE_OFF_ALT);
  endfunction

  function automatic cswl_state_t entry_st(input logic [2:0] m, input logic en);
    if (m == MODE_OFF || m == MODE_OFF_ALT) begin
      return CSWL_OFF;
    end
    if (m == MODE_WK) begin
      return CSWL_WK;
    end
    if (!m[2]) begin
      return CSWL_ACTIVE;
    end
    return en ? CSWL_WUF_DET : CSWL_WUP_DET2;
  endfunction

  assign setup = i_psel && !i_penable;
  assign wr = i_psel && i_penable && q.pready && i_pwrite;
  assign cfg_hit = (i_paddr >= ADDR_ID) && (i_paddr <= ADDR_DMASK_HI);
  assign new_mode = i_pwdata[CTRL_MODE_LSB +: 3];
  assign mode_wr = wr && (i_paddr == ADDR_CTRL) && (new_mode != q.mode);
  assign restart_entry = (i_pwr_mode == PWR_RESTART) && (q.pwr_prev != PWR_RESTART);
  assign low_pwr_ok = (i_pwr_mode == PWR_NORMAL) || (i_pwr_mode == PWR_STOP);
  assign rx_dom = !q.rx2;
  assign id_hit = q.ide ? (i_frame_ide && (((i_frame_id ^ q.id) & q.idm) == 29'h0))
                        : (!i_frame_ide && (((i_frame_id[10:0] ^ q.id[10:0]) & q.idm[10:0]) == 11'h0));
  assign dlc_hit = i_frame_dlc == q.dlc;
  assign data_hit = (q.dlc == 4'h0) || ((i_frame_data & q.dmask) != 64'h0);
  assign prot_err = i_err_stuff || i_err_crc || i_err_form;
  assign frame_good = i_frame_ok && !prot_err;
  assign counting = (q.st == CSWL_ACTIVE) || (q.st == CSWL_WUF_DET);
  assign error_count_field_clr = (q.flex && q.cdis) || q.mode == MODE_OFF || q.mode == MODE_OFF_ALT || q.mode == MODE_WK;
  assign incr = counting && prot_err && !error_count_field_clr && (q.error_count_field != ERROR_COUNT_FIELD_OVF);
  assign decr = counting && frame_good && !error_count_field_clr && (q.error_count_field != 6'h00);
  assign ovf = incr && (q.error_count_field == ERROR_COUNT_FIELD_MAX);
  // ignore first frames after bias on, then full qualification
  assign wake_frame = (q.st == CSWL_WUF_DET) && q.swk_en && frame_good && q.gate && (q.ign == IGN_LIM)
                      && id_hit && dlc_hit && data_hit;
  // second long dominant phase completes the pattern
  assign pat_hit = (q.pat_ph == 2'h2) && rx_dom && (q.dom_cnt == WAKE_LAST);
  assign sil_hit = !rx_dom && (q.sil_cnt == SIL_LAST);

  always_comb begin
    d = q;
    d.irq = 1'b0;
    d.restart = 1'b0;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    d.rx1 = i_bus_rx;
    d.rx2 = q.rx1;
    d.pwr_prev = i_pwr_mode;
    // restart entry; software set in the same cycle wins
    if (restart_entry) begin
      d.config_valid_bit = 1'b0;
      d.fw_sleep = 1'b0;
    end
    // Zero wait state: answer prepared during setup
    if (setup) begin
      d.pready = 1'b1;
      d.prdata = 32'h0;
      unique case (i_paddr)
        ADDR_CTRL: d.prdata[6:0] = {q.to_mask, q.config_valid_bit, q.cdis, q.flex, q.mode};
        ADDR_ID: d.prdata[29:0] = {q.ide, q.id};
        ADDR_IDMASK: d.prdata[28:0] = q.idm;
        ADDR_DLC: d.prdata[3:0] = q.dlc;
        ADDR_DMASK_LO: d.prdata = q.dmask[31:0];
        ADDR_DMASK_HI: d.prdata = q.dmask[63:32];
        ADDR_STAT: d.prdata[13:0] = {q.error_count_field, 1'b0, q.armed, q.sync, q.bsil, q.bto, q.system_error_flag, q.wfrm, q.wpat};
        ADDR_WAKE: d.prdata[WK_BUSWK] = q.buswk;
        default: d.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      unique case (i_paddr)
        ADDR_CTRL: begin
          // programmed mode never rewritten by hardware
          d.mode = new_mode;
          d.flex = i_pwdata[CTRL_FLEX];
          d.cdis = i_pwdata[CTRL_CDIS];
          d.config_valid_bit = i_pwdata[CTRL_CFGV];
          d.to_mask = i_pwdata[CTRL_TOMASK];
        end
        ADDR_ID: begin
          d.id = i_pwdata[28:0];
          d.ide = i_pwdata[ID_IDE];
        end
        ADDR_IDMASK: d.idm = i_pwdata[28:0];
        ADDR_DLC: d.dlc = i_pwdata[3:0];
        ADDR_DMASK_LO: d.dmask[31:0] = i_pwdata;
        ADDR_DMASK_HI: d.dmask[63:32] = i_pwdata;
        ADDR_STAT: begin
          // clear refused until valid bit set again
          if (i_pwdata[ST_SYSTEM_ERROR_FLAG] && !(q.mode[2] && !q.config_valid_bit)) begin
            d.system_error_flag = 1'b0;
          end
          if (i_pwdata[ST_BTO]) begin
            d.bto = 1'b0;
          end
        end
        ADDR_WAKE: begin
          if (i_pwdata[WK_BUSWK]) begin
            d.buswk = 1'b0;
          end
        end
        default: d.pslverr = 1'b0;
      endcase
    end
    // error set after the write so it wins over a same-cycle clear
    if (restart_entry && !q.fw_sleep && q.swk_en && swk_sel(q.mode)) begin
      d.system_error_flag = 1'b1;
    end
    // config change in normal mode invalidates the setup
    if (wr && cfg_hit && i_pwr_mode == PWR_NORMAL) begin
      d.config_valid_bit = 1'b0;
      if (q.swk_en && swk_sel(q.mode) && (q.st == CSWL_WUF_DET || q.st == CSWL_WUP_DET1)) begin
        d.system_error_flag = 1'b1;
        d.swk_en = 1'b0;
        d.st = CSWL_WUP_DET2;
        d.armed = 1'b1;
      end
    end
    // Pattern detector runs only in the pattern states
    if (q.st == CSWL_WK || q.st == CSWL_WUP_DET1 || q.st == CSWL_WUP_DET2) begin
      d.dom_cnt = rx_dom ? ((q.dom_cnt == WAKE_LAST) ? q.dom_cnt : q.dom_cnt + 16'h1) : 16'h0;
      if (q.pat_ph == 2'h0 && rx_dom && q.dom_cnt == WAKE_LAST) begin
        d.pat_ph = 2'h1;
      end else if (q.pat_ph == 2'h1 && !rx_dom) begin
        d.pat_ph = 2'h2;
      end else if (pat_hit) begin
        d.pat_ph = 2'h0;
      end
    end
    d.sil_cnt = rx_dom ? 24'h0 : ((q.sil_cnt == SIL_LAST) ? q.sil_cnt : q.sil_cnt + 24'h1);
    // reopen start of frame after enough recessive bits
    if (!q.gate && i_bit_valid) begin
      d.rec_cnt = i_bit_rec ? q.rec_cnt + 4'h1 : 4'h0;
      if (i_bit_rec && q.rec_cnt == RESYNC_BITS - 4'h1) begin
        d.gate = 1'b1;
      end
    end
    if (!mode_wr) begin
      if (counting && frame_good) begin
        d.sync = 1'b1;
      end else if (counting && prot_err) begin
        d.sync = 1'b0;
      end
      if (q.st == CSWL_WUF_DET && i_frame_ok && q.ign != IGN_LIM) begin
        d.ign = q.ign + 3'h1;
      end
      // count up on protocol error, down on good frame
      if (incr) begin
        d.error_count_field = q.error_count_field + 6'h1;
      end else if (decr) begin
        d.error_count_field = q.error_count_field - 6'h1;
      end
      // decoder holds off after each count increment or decrement
      if (incr || decr) begin
        d.gate = 1'b0;
        d.rec_cnt = 4'h0;
      end
      if (ovf && q.swk_en) begin
        d.swk_en = 1'b0;
        d.st = CSWL_WOKEN;
        d.armed = 1'b0;
        // error only in a selective mode
        if (swk_sel(q.mode)) begin
          d.system_error_flag = 1'b1;
        end
      end
      if (wake_frame) begin
        d.st = CSWL_WOKEN;
        d.wfrm = 1'b1;
        d.buswk = 1'b1;
        d.armed = 1'b0;
        d.fw_sleep = i_pwr_mode == PWR_SLEEP;
        d.restart = i_pwr_mode == PWR_SLEEP;
        d.irq = low_pwr_ok;
      end
      if (pat_hit) begin
        d.bsil = 1'b0;
        d.wpat = 1'b1;
        if (q.st == CSWL_WUP_DET1) begin
          d.st = CSWL_WUF_DET;
          d.error_count_field = 6'h00;
        end else begin
          d.st = CSWL_WOKEN;
          d.buswk = 1'b1;
          d.armed = 1'b0;
        end
      end
      // silence expiry, interrupt only, never a wake
      if (sil_hit && (q.st == CSWL_WUF_DET || q.st == CSWL_WUP_DET2)) begin
        d.bto = 1'b1;
        d.bsil = 1'b1;
        d.irq = d.irq || (q.to_mask && low_pwr_ok);
        if (q.st == CSWL_WUF_DET) begin
          // cleared on drop to first pattern state
          d.st = CSWL_WUP_DET1;
          d.error_count_field = 6'h00;
        end
      end
    end else begin
      d.wpat = 1'b0;
      // Stale sleep wake must not excuse a later restart
      d.fw_sleep = 1'b0;
      d.error_count_field = 6'h00;
      d.gate = 1'b1;
      if (swk_sel(new_mode)) begin
        d.wfrm = 1'b0;
      end
      // config check when entering a selective mode
      if (swk_sel(new_mode) && !swk_sel(q.mode)) begin
        d.swk_en = d.config_valid_bit;
        d.system_error_flag = !d.config_valid_bit;
        d.ign = 3'h0;
      end else if (!swk_sel(new_mode)) begin
        d.swk_en = 1'b0;
      end
      d.st = entry_st(new_mode, d.swk_en);
      // armed on correct enable, or after error in second pattern state
      d.armed = swk_sel(new_mode);
    end
    // off modes and disable bits hold the counter clear
    if (error_count_field_clr) begin
      d.error_count_field = 6'h00;
    end
    // armed dropped with top mode bit
    if (!d.mode[2]) begin
      d.armed = 1'b0;
    end
    if (d.st != q.st) begin
      d.pat_ph = 2'h0;
      d.dom_cnt = 16'h0;
      d.sil_cnt = 24'h0;
    end
    d.woken = d.st == CSWL_WOKEN;
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      q <= '0;
      q.rx1 <= 1'b1;
      q.rx2 <= 1'b1;
      q.gate <= 1'b1;
    end else if (i_clk_en) begin
      q <= d;
    end
  end

  assign o_prdata = q.prdata;
  assign o_pready = q.pready;
  assign o_pslverr = q.pslverr;
  assign o_sof_enable = q.gate;
  assign o_xcvr_woken = q.woken;
  assign o_swk_armed = q.armed;
  assign o_irq = q.irq;
  assign o_restart_req = q.restart;

  default clocking cb @(posedge i_mclk iff i_clk_en);
  endclocking
  default disable iff (i_sys_rst);

  frame_wake_flags_a: assert property (wake_frame && !mode_wr |=> q.wfrm && q.buswk && q.woken)
    else $error("frame wake did not set flags");
  frame_filter_a: assert property ($rose(q.wfrm) |-> $past(id_hit && dlc_hit && data_hit && q.swk_en))
    else $error("frame wake without full match");
  overflow_fallback_a: assert property (ovf && q.swk_en && !mode_wr |=> q.error_count_field == 6'h20 && !q.swk_en && q.woken)
    else $error("overflow fallback missing");
  count_gate_a: assert property ((incr || decr) && !mode_wr |=> !q.gate ##1 !q.gate)
    else $error("decoder not held after count change");
  frozen_woken_a: assert property (q.st == CSWL_WOKEN && !mode_wr && !error_count_field_clr |=> $stable(q.error_count_field))
    else $error("counter moved while woken");
  off_clear_a: assert property (q.mode == MODE_OFF || (q.flex && q.cdis) |=> q.error_count_field == 6'h00)
    else $error("counter not held clear");
  clear_refuse_a: assert property (wr && i_paddr == ADDR_STAT && q.mode[2] && !q.config_valid_bit && q.system_error_flag
                                   |=> q.system_error_flag)
    else $error("system error cleared without valid bit");
  silence_flags_a: assert property (sil_hit && q.st == CSWL_WUF_DET && !mode_wr |=> q.bto && q.bsil
                                    && q.st == CSWL_WUP_DET1 && !q.restart)
    else $error("silence expiry flags missing");
  armed_drop_a: assert property (!q.mode[2] |-> !q.armed)
    else $error("armed while top mode bit clear");
  apb_answer_a: assert property (setup |=> q.pready ##1 !q.pready)
    else $error("bus answer not one cycle");

  frame_wake_c: cover property (wake_frame);
  pattern_wake_c: cover property (pat_hit && q.st == CSWL_WK);
  overflow_c: cover property (ovf && q.swk_en);
  silence_c: cover property (sil_hit && q.st == CSWL_WUF_DET);

endmodule
`default_nettype wire

// ### cswl_bus_node.sv
// Model of the far CAN nodes and the bit decoder
`timescale 1ns/1ps
`default_nettype none
module cswl_bus_node #(
  parameter int WAKE_CYC = 3
) (
  input wire logic i_mclk,
  output logic o_bus_rx,
  output logic o_bit_valid,
  output logic o_bit_rec,
  output logic o_frame_ok,
  output logic o_frame_ide,
  output logic [28:0] o_frame_id,
  output logic [3:0] o_frame_dlc,
  output logic [63:0] o_frame_data,
  output logic o_err_stuff,
  output logic o_err_crc,
  output logic o_err_form
);
  initial begin
    o_bus_rx = 1'b1;
    {o_bit_valid, o_bit_rec, o_frame_ok, o_frame_ide} = 4'h0;
    {o_frame_id, o_frame_dlc, o_frame_data} = '0;
    {o_err_stuff, o_err_crc, o_err_form} = 3'h0;
  end
  // Fields scrambled outside the pulse so stale values never match
  // Error code 0 stuff, 1 CRC, 2 form, any other none
  task automatic send_frame(input logic ide, input logic [28:0] id, input logic [3:0] dlc,
                            input logic [63:0] d, input int err = 3);
    @(posedge i_mclk);
    o_frame_ok <= 1'b1;
    {o_err_stuff, o_err_crc, o_err_form} <= {err == 0, err == 1, err == 2};
    {o_frame_ide, o_frame_id, o_frame_dlc, o_frame_data} <= {ide, id, dlc, d};
    @(posedge i_mclk);
    o_frame_ok <= 1'b0;
    {o_err_stuff, o_err_crc, o_err_form} <= 3'h0;
    {o_frame_ide, o_frame_id, o_frame_dlc, o_frame_data} <= ~{ide, id, dlc, d};
  endtask
  task automatic send_err(input int k);
    @(posedge i_mclk);
    {o_err_stuff, o_err_crc, o_err_form} <= {k == 0, k == 1, k == 2};
    @(posedge i_mclk);
    {o_err_stuff, o_err_crc, o_err_form} <= 3'h0;
  endtask
  task automatic rec_bits(input int n, input logic lvl = 1'b1);
    @(posedge i_mclk);
    o_bit_valid <= 1'b1;
    o_bit_rec <= lvl;
    repeat (n) @(posedge i_mclk);
    o_bit_valid <= 1'b0;
    o_bit_rec <= 1'b0;
  endtask
  task automatic wake_pattern();
    repeat (2) begin
      // Toggle away from the recessive idle level and back
      @(posedge i_mclk);
      o_bus_rx <= !o_bus_rx;
      repeat (WAKE_CYC + 2) @(posedge i_mclk);
      o_bus_rx <= !o_bus_rx;
      repeat (4) @(posedge i_mclk);
    end
    repeat (6) @(posedge i_mclk);
  endtask
endmodule
`default_nettype wire

// ### cswl_tb.sv
// Self-checking bench for the selective wake logic
`timescale 1ns/1ps
`default_nettype none
module testbench import cswl_pkg::*; ();
  localparam int SIL = 2000;
  localparam int WK = 3;
  localparam int IGN = 2;
  localparam logic [31:0] CF = 32'h1 << CTRL_CFGV;
  localparam logic [31:0] SE = 32'h1 << ST_SYSTEM_ERROR_FLAG;
  localparam logic [31:0] AR = 32'h1 << ST_ARMED;
  localparam logic [31:0] WP = 32'h1 << ST_WPAT;
  localparam logic [31:0] WF = 32'h1 << ST_WFRM;
  localparam logic [31:0] BT = 32'h1 << ST_BTO;
  localparam logic [31:0] BS = 32'h1 << ST_BSIL;
  localparam logic [31:0] EC = 32'h3f << ST_ERROR_COUNT_FIELD_LSB;
  localparam logic [31:0] SELECTIVE_WAKE = CF | 32'(MODE_SWK);
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] pwr = PWR_NORMAL;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, slv, sof, woken, armed, irq, rreq, rx, bv, brec, fok, fide, e_st, e_crc, e_fm;
  logic [1:0] pm;
  logic [28:0] fid, cid;
  logic [3:0] fdlc;
  logic [63:0] fdat, dr;
  int failures = 0;
  int total_checks = 0;
  int irq_cnt = 0;
  int rr_cnt = 0;
  int r0;
  int exp_cnt = 0;
  int i0;
  int kinds[$] = '{0, 1, 2};
  logic exp_wk = 1'b0;

  initial forever #50 clk = ~clk;
  always @(posedge clk) if (irq === 1'b1) irq_cnt++;
  always @(posedge clk) if (rreq === 1'b1) rr_cnt++;

  cswl_core #(.SILENCE_CYC(SIL), .WAKE_CYC(WK), .IGN_FRAMES(IGN)) cswl_core_inst (
    .i_mclk(clk), .i_sys_rst(rst), .i_clk_en(clk_en), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_bus_rx(rx), .i_pwr_mode(pwr), .i_bit_valid(bv), .i_bit_rec(brec),
    .i_frame_ok(fok), .i_frame_ide(fide), .i_frame_id(fid), .i_frame_dlc(fdlc), .i_frame_data(fdat),
    .i_err_stuff(e_st), .i_err_crc(e_crc), .i_err_form(e_fm), .o_sof_enable(sof),
    .o_xcvr_woken(woken), .o_swk_armed(armed), .o_irq(irq), .o_restart_req(rreq));
  cswl_bus_node #(.WAKE_CYC(WK)) node (
    .i_mclk(clk), .o_bus_rx(rx), .o_bit_valid(bv), .o_bit_rec(brec), .o_frame_ok(fok),
    .o_frame_ide(fide), .o_frame_id(fid), .o_frame_dlc(fdlc), .o_frame_data(fdat),
    .o_err_stuff(e_st), .o_err_crc(e_crc), .o_err_form(e_fm));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
    apb(1'b0, a, 32'h0);
    check(rdata & m, e, s);
  endtask
  // Burns the frames that may be ignored after enabling
  task automatic rearm(input logic [31:0] v);
    apb(1'b1, ADDR_CTRL, CF | 32'(MODE_NORMAL));
    apb(1'b1, ADDR_CTRL, v);
    exp_cnt = 0;
    exp_wk = 1'b0;
    repeat (IGN) node.send_frame(1'b0, cid, 4'h2, 64'h100);
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    void'($urandom(31));
    cid = 29'($urandom & 32'h7ff);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rchk(ADDR_STAT, 32'hffffffff, 32'h0, "status reset");
    apb(1'b0, 8'h20, 32'h0);
    check(32'(slv), 32'h1, "unmapped");
    check(rdata, 32'h0, "unmapped data");
    $display("test reset done");
    apb(1'b1, ADDR_ID, 32'(cid));
    apb(1'b1, ADDR_IDMASK, 32'h7f0);
    apb(1'b1, ADDR_DLC, 32'h2);
    apb(1'b1, ADDR_DMASK_LO, 32'h100);
    apb(1'b1, ADDR_DMASK_HI, 32'h0);
    rearm(SELECTIVE_WAKE);
    rchk(ADDR_STAT, SE | AR, AR, "enable");
    check(32'(armed), 32'h1, "armed pin");
    check(32'(woken), 32'h0, "early frames");
    node.send_frame(1'b0, cid ^ 29'h10, 4'h2, 64'h100);
    node.send_frame(1'b0, cid, 4'h3, 64'h100);
    node.send_frame(1'b0, cid, 4'h2, 64'hff);
    repeat (2) @(posedge clk);
    check(32'(woken), 32'h0, "mismatch");
    node.send_frame(1'b0, cid, 4'h2, 64'h100, 0);
    @(posedge clk);
    check(32'(sof), 32'h0, "sof err");
    check(32'(woken), 32'h0, "error frame");
    node.rec_bits(5);
    node.rec_bits(1, 1'b0);
    node.rec_bits(5);
    repeat (2) @(posedge clk);
    check(32'(sof), 32'h0, "sof 5");
    node.rec_bits(1);
    repeat (2) @(posedge clk);
    check(32'(sof), 32'h1, "sof 6");
    i0 = irq_cnt;
    r0 = rr_cnt;
    pm = 2'($urandom % 3);
    pwr <= pm;
    dr = ({$urandom, $urandom} & 64'hffff) | 64'h100;
    node.send_frame(1'b0, cid ^ 29'($urandom & 32'hf), 4'h2, dr);
    repeat (2) @(posedge clk);
    check(32'(woken), 32'h1, "frame wake");
    check(32'(irq_cnt - i0), 32'(pm != PWR_SLEEP), "wake irq");
    check(32'(rr_cnt - r0), 32'(pm == PWR_SLEEP), "wake restart");
    pwr <= PWR_NORMAL;
    rchk(ADDR_STAT, WF | AR | EC, WF, "wake flags");
    rchk(ADDR_WAKE, 32'h1, 32'h1, "bus wake");
    rchk(ADDR_CTRL, 32'h7, 32'(MODE_SWK), "mode");
    node.rec_bits(6);
    $display("test frame wake done");
    rearm(SELECTIVE_WAKE);
    rchk(ADDR_STAT, WF, 32'h0, "rearm");
    for (int i = 0; i < 35; i++) begin
      node.send_err(kinds[i % 3]);
      if (!exp_wk) exp_cnt++;
      if (exp_cnt == 32) exp_wk = 1'b1;
      node.rec_bits(6);
      if (i == 4) begin
        node.send_frame(1'b0, cid, 4'hf, 64'h0);
        exp_cnt--;
        node.rec_bits(6);
      end
      rchk(ADDR_STAT, EC, 32'(exp_cnt) << ST_ERROR_COUNT_FIELD_LSB, "count");
      check(32'(woken), 32'(exp_wk), "overflow");
    end
    rchk(ADDR_STAT, SE | AR, SE, "ovf flags");
    $display("test counter done");
    rearm(SELECTIVE_WAKE);
    apb(1'b1, ADDR_DLC, 32'h2);
    rchk(ADDR_STAT, SE | AR, SE | AR, "cfg write");
    rchk(ADDR_CTRL, CF, 32'h0, "valid");
    apb(1'b1, ADDR_STAT, SE);
    rchk(ADDR_STAT, SE, SE, "refused");
    apb(1'b1, ADDR_CTRL, SELECTIVE_WAKE);
    apb(1'b1, ADDR_STAT, SE);
    rchk(ADDR_STAT, SE, 32'h0, "cleared");
    node.wake_pattern();
    check(32'(woken), 32'h1, "pattern");
    rchk(ADDR_STAT, WP | AR, WP, "pat flag");
    $display("test config done");
    rearm(SELECTIVE_WAKE | (32'h1 << CTRL_TOMASK));
    rchk(ADDR_STAT, WP, 32'h0, "pat rearm");
    i0 = irq_cnt;
    repeat (SIL + 20) @(posedge clk);
    rchk(ADDR_STAT, BT | BS | AR, BT | BS | AR, "silence");
    check(32'(irq_cnt - i0), 32'h1, "to irq");
    check(32'(woken), 32'h0, "to wake");
    node.wake_pattern();
    rchk(ADDR_STAT, BS | WP, WP, "sil clear");
    apb(1'b1, ADDR_STAT, BT);
    rchk(ADDR_STAT, BT, 32'h0, "to clear");
    pwr <= PWR_RESTART;
    repeat (2) @(posedge clk);
    pwr <= PWR_NORMAL;
    rchk(ADDR_STAT, SE, SE, "restart");
    rchk(ADDR_CTRL, CF, 32'h0, "rst valid");
    $display("test silence done");
    apb(1'b1, ADDR_CTRL, (32'h1 << CTRL_FLEX) | (32'h1 << CTRL_CDIS) | 32'(MODE_NORMAL));
    node.send_err(1);
    node.rec_bits(6);
    rchk(ADDR_STAT, EC, 32'h0, "held");
    apb(1'b1, ADDR_CTRL, 32'(MODE_NORMAL));
    node.send_err(2);
    node.rec_bits(6);
    rchk(ADDR_STAT, EC, 32'h1 << ST_ERROR_COUNT_FIELD_LSB, "normal");
    // Error pulse while frozen is lost, the next one counts
    repeat (2) begin
      clk_en <= !clk_en;
      node.send_err(2);
    end
    rchk(ADDR_STAT, EC, 32'h2 << ST_ERROR_COUNT_FIELD_LSB, "frozen");
    apb(1'b1, ADDR_CTRL, 32'(MODE_OFF_ALT));
    rchk(ADDR_STAT, EC, 32'h0, "off");
    apb(1'b1, ADDR_CTRL, 32'(MODE_WK));
    node.wake_pattern();
    check(32'(woken), 32'h1, "wk wake");
    rchk(ADDR_STAT, WP, WP, "wk flag");
    $display("test clear done");
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
